//--- bench/aisf_host_model.sv
// Host controller model issuing single-byte register strobes.
// Assumes the bank samples strobes on the rising clock edge.
`timescale 1ns/100ps

module aisf_host_model
(
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse so stale values are never reused
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rvalid_i ? rdata_i : 8'hxx;
    endtask
endmodule

//--- bench/aisf_regs_monitor.sv
// Checker on the register bank ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps

module aisf_regs_monitor
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic tap_event_active_flag_i,
    input wire logic tap_irq_en_i,
    input wire logic fall_motion_event_active_flag_i,
    input wire logic fall_motion_irq_en_i,
    input wire logic orientation_change_i,
    input wire logic orientation_irq_en_i,
    input wire logic tap_irq_flag_o,
    input wire logic fall_motion_irq_flag_o,
    input wire logic sample_ready_irq_flag_o,
    input wire logic orientation_irq_flag_o,
    input wire logic highpass_output_select_o,
    input wire logic [1:0] range_select_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////
    wire logic tap_on = tap_event_active_flag_i && tap_irq_en_i;
    wire logic fm_on = fall_motion_event_active_flag_i && fall_motion_irq_en_i;
    wire logic or_on = orientation_change_i && orientation_irq_en_i;
    wire logic rd_tap = reg_rd_i && reg_addr_i == 8'h22;
    wire logic rd_fm = reg_rd_i && reg_addr_i == 8'h16;
    wire logic rd_xyz = reg_rd_i && reg_addr_i >= 8'h01 && reg_addr_i <= 8'h06;
    wire logic [7:0] src_w = {3'h0, orientation_irq_flag_o, tap_irq_flag_o,
        fall_motion_irq_flag_o, 1'b0, sample_ready_irq_flag_o};

    ////////////////////////////////////////////////////////////////////////
    property p_tap_set;
        $rose(tap_on) |=> tap_irq_flag_o;
    endproperty
    a_tap_set: assert property (p_tap_set)
        else $error("tap flag not set");
    property p_tap_clr;
        tap_irq_flag_o && rd_tap && !$rose(tap_on) |=> !tap_irq_flag_o;
    endproperty
    a_tap_clr: assert property (p_tap_clr)
        else $error("tap flag kept");
    property p_tap_hold;
        tap_irq_flag_o && !rd_tap |=> tap_irq_flag_o;
    endproperty
    a_tap_hold: assert property (p_tap_hold)
        else $error("tap flag lost");
    property p_fm_set;
        $rose(fm_on) |=> fall_motion_irq_flag_o;
    endproperty
    a_fm_set: assert property (p_fm_set)
        else $error("fall flag not set");
    property p_fm_clr;
        fall_motion_irq_flag_o && rd_fm && !$rose(fm_on) |=>
            !fall_motion_irq_flag_o;
    endproperty
    a_fm_clr: assert property (p_fm_clr)
        else $error("fall flag kept");
    property p_sr_hold;
        sample_ready_irq_flag_o && !rd_xyz |=> sample_ready_irq_flag_o;
    endproperty
    a_sr_hold: assert property (p_sr_hold)
        else $error("ready flag lost");
    property p_or_clr;
        orientation_irq_flag_o && reg_rd_i && reg_addr_i == 8'h10 &&
            !$rose(or_on) |=> !orientation_irq_flag_o;
    endproperty
    a_or_clr: assert property (p_or_clr)
        else $error("orient flag kept");
    property p_src;
        reg_rd_i && reg_addr_i == 8'h0c |=>
            reg_rvalid_o && reg_rdata_o == $past(src_w);
    endproperty
    a_src: assert property (p_src)
        else $error("source read wrong");
    property p_id;
        reg_rd_i && reg_addr_i == 8'h0d |=>
            reg_rvalid_o && reg_rdata_o == aisf_pkg::IDENTITY_CODE;
    endproperty
    a_id: assert property (p_id)
        else $error("identity read wrong");
    property p_range;
        reg_wr_i && reg_addr_i == 8'h0e |=>
            range_select_o == $past(reg_wdata_i[1:0]) &&
            highpass_output_select_o == $past(reg_wdata_i[4]);
    endproperty
    a_range: assert property (p_range)
        else $error("range write wrong");
endmodule

//--- bench/aisf_regs_test.sv
// Testbench for the interrupt source and filter setup bank.
// Assumes the host model drives all register strobes at falling edges.
`timescale 1ns/100ps

module aisf_regs_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    int fail_count = 0;
    int check_count = 0;
    logic [4:0] ev_r = 5'h00;
    logic [3:0] en_r = 4'h0;
    logic [2:0] rate_r = 3'h0;
    logic [1:0] mode_r = 2'h0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic rvalid;
    logic tap_f;
    logic fm_f;
    logic sr_f;
    logic or_f;
    logic hp_sel;
    logic rsv;
    logic byp;
    logic lpe;
    logic [1:0] rsel;
    logic [3:0] fs_g;
    logic [3:0] cexp;
    logic [3:0] exp_c;
    logic [3:0] fs_t [4] = '{4'h2, 4'h4, 4'h8, 4'h0};
    // Corner exponent at select 00, one nibble per rate, rate 0 lowest
    logic [31:0] base_t [4] = '{32'h66667899, 32'h44467899, 32'h99999999,
        32'h33356789};

    always #2.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    aisf_regs aisf_regs_inst (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .tap_event_active_flag_i(ev_r[0]), .tap_irq_en_i(en_r[0]),
        .fall_motion_event_active_flag_i(ev_r[1]),
        .fall_motion_irq_en_i(en_r[1]), .axes_ready_flag_i(ev_r[2]),
        .axes_overwrite_flag_i(ev_r[4]), .sample_ready_irq_en_i(en_r[2]),
        .orientation_change_i(ev_r[3]), .orientation_irq_en_i(en_r[3]),
        .rate_index_i(rate_r), .oversampling_mode_i(mode_r),
        .tap_irq_flag_o(tap_f), .fall_motion_irq_flag_o(fm_f),
        .sample_ready_irq_flag_o(sr_f), .orientation_irq_flag_o(or_f),
        .highpass_output_select_o(hp_sel), .range_select_o(rsel),
        .full_scale_g_o(fs_g), .range_reserved_o(rsv),
        .tap_highpass_bypass_o(byp), .tap_lowpass_enable_o(lpe),
        .highpass_corner_exp_o(cexp));

    aisf_host_model aisf_host_model_inst (.clk_sys_i(clk_sys),
        .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        aisf_host_model_inst.rd_reg(a, d);
        chk(d, e);
    endtask

    task automatic rd_any(input logic [7:0] a);
        logic [7:0] d;
        aisf_host_model_inst.rd_reg(a, d);
    endtask

    // Raise an event, check set, hold, clear, no re-set, and masking
    task automatic irq_case(input int e, input int n, input logic [7:0] m);
        @(negedge clk_sys);
        en_r[n] = 1'b1;
        ev_r[e] = 1'b1;
        rd_chk(8'h0c, m);
        chk({3'h0, or_f, tap_f, fm_f, 1'b0, sr_f}, m);
        rd_chk(8'h0d, 8'h5c);
        rd_chk(8'h0c, m);
        if (e == 2 || e == 4)
        begin
            rd_any(8'h01);
            rd_any(8'h04);
            rd_chk(8'h0c, m);
            rd_any(8'h05);
        end
        else
            rd_any(e == 0 ? 8'h22 : (e == 1 ? 8'h16 : 8'h10));
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h0c, 8'h00);
        chk({3'h0, or_f, tap_f, fm_f, 1'b0, sr_f}, 8'h00);
        ev_r[e] = 1'b0;
        en_r[n] = 1'b0;
        @(negedge clk_sys);
        ev_r[e] = 1'b1;
        rd_chk(8'h0c, 8'h00);
        ev_r[e] = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        chk({4'h0, fs_g}, 8'h02);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h0d, 8'h5c);
        rd_chk(8'h0e, 8'h00);
        rd_chk(8'h0f, 8'h00);
        aisf_host_model_inst.wr_reg(8'h0d, 8'hff);
        aisf_host_model_inst.wr_reg(8'h0c, 8'hff);
        rd_chk(8'h0d, 8'h5c);
        rd_chk(8'h0c, 8'h00);
        for (int v = 0; v < 4; v++)
        begin
            aisf_host_model_inst.wr_reg(8'h0e, {3'h0, v[0], 2'h0, v[1:0]});
            chk({3'h0, hp_sel, rsv, 1'b0, rsel},
                {3'h0, v[0], v == 3, 1'b0, v[1:0]});
            chk({4'h0, fs_g}, {4'h0, fs_t[v]});
            rd_chk(8'h0e, {3'h0, v[0], 2'h0, v[1:0]});
        end
        for (int b = 0; b < 4; b++)
        begin
            aisf_host_model_inst.wr_reg(8'h0f, {2'h0, b[1:0], 4'h0});
            chk({6'h0, byp, lpe}, {6'h0, b[1:0]});
        end
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        rd_chk(8'h0e, 8'h00);
        rd_chk(8'h0f, 8'h00);
        // Mode in bits 6:5, rate in bits 4:2, cutoff select in bits 1:0
        for (int i = 0; i < 128; i++)
        begin
            mode_r = i[6:5];
            rate_r = i[4:2];
            aisf_host_model_inst.wr_reg(8'h0f, {6'h0, i[1:0]});
            @(negedge clk_sys);
            exp_c = base_t[i[6:5]][4*i[4:2] +: 4] - {2'h0, i[1:0]};
            chk({4'h0, cexp}, {4'h0, exp_c});
        end
        rd_chk(8'h0f, 8'h03);
        irq_case(0, 0, 8'h08);
        irq_case(1, 1, 8'h04);
        irq_case(2, 2, 8'h01);
        irq_case(4, 2, 8'h01);
        irq_case(3, 3, 8'h10);
        finish_test();
    end

    initial
    begin
        #50000;
        fail_count++;
        finish_test();
    end
endmodule

bind aisf_regs aisf_regs_monitor aisf_regs_monitor_inst (.*);

//--- logic/aisf_pkg.sv
// Constants for the accelerometer interrupt status and filter setup bank.
// Assumes a serial port front end that turns bus frames into register
// read and write strobes on the system clock.

package aisf_pkg;

    localparam logic [7:0] OFS_X_MSB = 8'h01;
    localparam logic [7:0] OFS_Z_LSB = 8'h06;
    localparam logic [7:0] OFS_INT_SOURCE = 8'h0c;
    localparam logic [7:0] OFS_DEVICE_IDENTITY = 8'h0d;
    localparam logic [7:0] OFS_OUTPUT_RANGE_CONFIG = 8'h0e;
    localparam logic [7:0] OFS_HIGHPASS_CUTOFF_CONFIG = 8'h0f;
    localparam logic [7:0] OFS_ORIENTATION_STATUS = 8'h10;
    localparam logic [7:0] OFS_FALL_MOTION_SOURCE = 8'h16;
    localparam logic [7:0] OFS_TAP_SOURCE = 8'h22;

    // Identity code: value is arbitrary
    localparam logic [7:0] IDENTITY_CODE = 8'h5c;

    localparam int BIT_SRC_ORIENT = 4;
    localparam int BIT_SRC_TAP = 3;
    localparam int BIT_SRC_FALL = 2;
    localparam int BIT_SRC_READY = 0;
    localparam int BIT_HP_OUT = 4;
    localparam int BIT_TAP_HP_BYP = 5;
    localparam int BIT_TAP_LP_EN = 4;

    localparam logic [1:0] RANGE_RESET = 2'h0;
    localparam logic [1:0] RANGE_2G = 2'h0;
    localparam logic [1:0] RANGE_4G = 2'h1;
    localparam logic [1:0] RANGE_8G = 2'h2;
    localparam logic [1:0] CUTOFF_RESET = 2'h0;

    // Oversampling modes
    localparam logic [1:0] OSM_NORMAL = 2'h0;
    localparam logic [1:0] OSM_LOW_NOISE = 2'h1;
    localparam logic [1:0] OSM_HIGH_RES = 2'h2;
    localparam logic [1:0] OSM_LOW_POWER = 2'h3;

    // Rate index: 0 800, 1 400, 2 200, 3 100, 4 50, 5 12.5, 6 6.25, 7 1.56 Hz
    // Corner is 2**exp in 1/32 Hz units: 9 is 16 Hz, 0 is 1/32 Hz
    localparam logic [31:0] CORNER_EXP_NORMAL = 32'h66667899;
    localparam logic [31:0] CORNER_EXP_LOW_NOISE = 32'h44467899;
    localparam logic [31:0] CORNER_EXP_HIGH_RES = 32'h99999999;
    localparam logic [31:0] CORNER_EXP_LOW_POWER = 32'h33356789;

endpackage

//--- logic/aisf_regs.sv
// Interrupt source flags, identity, output range and high-pass cutoff
// registers of a three-axis accelerometer.
// Assumes event, enable and rate inputs and the register strobes all come
// from logic on clk_sys_i; no synchronisers are needed on them.
`timescale 1ns/100ps

module aisf_regs
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic tap_event_active_flag_i,
    input wire logic tap_irq_en_i,
    input wire logic fall_motion_event_active_flag_i,
    input wire logic fall_motion_irq_en_i,
    input wire logic axes_ready_flag_i,
    input wire logic axes_overwrite_flag_i,
    input wire logic sample_ready_irq_en_i,
    input wire logic orientation_change_i,
    input wire logic orientation_irq_en_i,
    input wire logic [2:0] rate_index_i,
    input wire logic [1:0] oversampling_mode_i,
    output logic tap_irq_flag_o,
    output logic fall_motion_irq_flag_o,
    output logic sample_ready_irq_flag_o,
    output logic orientation_irq_flag_o,
    output logic highpass_output_select_o,
    output logic [1:0] range_select_o,
    output logic [3:0] full_scale_g_o,
    output logic range_reserved_o,
    output logic tap_highpass_bypass_o,
    output logic tap_lowpass_enable_o,
    output logic [3:0] highpass_corner_exp_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (ADDR_W < 8)
    begin : g_addr_chk
        $error("aisf_regs: ADDR_W must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [7:0] addr_lo;
    logic addr_hi_zero;
    logic rd_tap_src, rd_fall_src, rd_orient;
    logic rd_x, rd_y, rd_z;
    logic wr_range, wr_cutoff;

    always_comb
    begin
        addr_lo = reg_addr_i[7:0];
        addr_hi_zero = (reg_addr_i >> 8) == '0;
        rd_tap_src = 1'b0;
        rd_fall_src = 1'b0;
        rd_orient = 1'b0;
        rd_x = 1'b0;
        rd_y = 1'b0;
        rd_z = 1'b0;
        if (reg_rd_i && addr_hi_zero)
        begin
            if (addr_lo == aisf_pkg::OFS_TAP_SOURCE)
                rd_tap_src = 1'b1;
            else if (addr_lo == aisf_pkg::OFS_FALL_MOTION_SOURCE)
                rd_fall_src = 1'b1;
            else if (addr_lo == aisf_pkg::OFS_ORIENTATION_STATUS)
                rd_orient = 1'b1;
            else if (addr_lo >= aisf_pkg::OFS_X_MSB
                     && addr_lo <= aisf_pkg::OFS_Z_LSB)
            begin
                // Either byte of an axis counts as reading that axis
                rd_x = addr_lo < 8'h03;
                rd_y = addr_lo == 8'h03 || addr_lo == 8'h04;
                rd_z = addr_lo > 8'h04;
            end
        end
    end

    always_comb
    begin
        wr_range = 1'b0;
        wr_cutoff = 1'b0;
        // Identity and source registers have no write path
        if (reg_wr_i && addr_hi_zero)
        begin
            if (addr_lo == aisf_pkg::OFS_OUTPUT_RANGE_CONFIG)
                wr_range = 1'b1;
            else if (addr_lo == aisf_pkg::OFS_HIGHPASS_CUTOFF_CONFIG)
                wr_cutoff = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt source flags
    logic tap_lvl, fall_lvl, ready_lvl, orient_lvl;
    logic tap_prev_r, fall_prev_r, ready_prev_r, orient_prev_r;
    logic tap_flag_r, fall_flag_r, ready_flag_r, orient_flag_r;
    logic [2:0] axes_seen_r;
    logic tap_flag_nxt, fall_flag_nxt, ready_flag_nxt, orient_flag_nxt;
    logic [2:0] axes_seen_nxt;
    logic [2:0] axes_now;
    logic ready_clr;

    always_comb
    begin
        tap_lvl = tap_event_active_flag_i && tap_irq_en_i;
        fall_lvl = fall_motion_event_active_flag_i
                   && fall_motion_irq_en_i;
        ready_lvl = (axes_ready_flag_i || axes_overwrite_flag_i)
                    && sample_ready_irq_en_i;
        orient_lvl = orientation_change_i && orientation_irq_en_i;

        // Set beats clear when both land in one cycle
        tap_flag_nxt = (tap_lvl && !tap_prev_r)
                       || (tap_flag_r && !rd_tap_src);
        fall_flag_nxt = (fall_lvl && !fall_prev_r)
                        || (fall_flag_r && !rd_fall_src);
        orient_flag_nxt = (orient_lvl && !orient_prev_r)
                          || (orient_flag_r && !rd_orient);

        axes_now = axes_seen_r | {rd_z, rd_y, rd_x};
        ready_clr = &axes_now;
        axes_seen_nxt = ready_clr ? 3'h0 : axes_now;
        ready_flag_nxt = (ready_lvl && !ready_prev_r)
                         || (ready_flag_r && !ready_clr);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            tap_prev_r <= 1'b0;
            fall_prev_r <= 1'b0;
            ready_prev_r <= 1'b0;
            orient_prev_r <= 1'b0;
            tap_flag_r <= 1'b0;
            fall_flag_r <= 1'b0;
            ready_flag_r <= 1'b0;
            orient_flag_r <= 1'b0;
            axes_seen_r <= 3'h0;
        end
        else
        begin
            tap_prev_r <= tap_lvl;
            fall_prev_r <= fall_lvl;
            ready_prev_r <= ready_lvl;
            orient_prev_r <= orient_lvl;
            tap_flag_r <= tap_flag_nxt;
            fall_flag_r <= fall_flag_nxt;
            ready_flag_r <= ready_flag_nxt;
            orient_flag_r <= orient_flag_nxt;
            axes_seen_r <= axes_seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic hp_out_r, tap_hp_byp_r, tap_lp_en_r;
    logic [1:0] range_r, cutoff_r;
    logic hp_out_nxt, tap_hp_byp_nxt, tap_lp_en_nxt;
    logic [1:0] range_nxt, cutoff_nxt;

    always_comb
    begin
        hp_out_nxt = hp_out_r;
        range_nxt = range_r;
        tap_hp_byp_nxt = tap_hp_byp_r;
        tap_lp_en_nxt = tap_lp_en_r;
        cutoff_nxt = cutoff_r;
        if (wr_range)
        begin
            hp_out_nxt = reg_wdata_i[aisf_pkg::BIT_HP_OUT];
            range_nxt = reg_wdata_i[1:0];
        end
        if (wr_cutoff)
        begin
            tap_hp_byp_nxt = reg_wdata_i[aisf_pkg::BIT_TAP_HP_BYP];
            tap_lp_en_nxt = reg_wdata_i[aisf_pkg::BIT_TAP_LP_EN];
            cutoff_nxt = reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            hp_out_r <= 1'b0;
            range_r <= aisf_pkg::RANGE_RESET;
            tap_hp_byp_r <= 1'b0;
            tap_lp_en_r <= 1'b0;
            cutoff_r <= aisf_pkg::CUTOFF_RESET;
        end
        else
        begin
            hp_out_r <= hp_out_nxt;
            range_r <= range_nxt;
            tap_hp_byp_r <= tap_hp_byp_nxt;
            tap_lp_en_r <= tap_lp_en_nxt;
            cutoff_r <= cutoff_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Range decode and high-pass corner

    logic [3:0] fs_g_nxt;
    logic fs_rsvd_nxt;
    logic [31:0] exp_row;
    logic [3:0] base_exp;
    logic [3:0] corner_nxt;
    logic [3:0] fs_g_r;
    logic fs_rsvd_r;
    logic [3:0] corner_r;

    always_comb
    begin
        fs_rsvd_nxt = 1'b0;
        case (range_nxt)
            aisf_pkg::RANGE_2G: fs_g_nxt = 4'h2;
            aisf_pkg::RANGE_4G: fs_g_nxt = 4'h4;
            aisf_pkg::RANGE_8G: fs_g_nxt = 4'h8;
            default:
            begin
                fs_g_nxt = 4'h0;
                fs_rsvd_nxt = 1'b1;
            end
        endcase

        case (oversampling_mode_i)
            aisf_pkg::OSM_NORMAL:
                exp_row = aisf_pkg::CORNER_EXP_NORMAL;
            aisf_pkg::OSM_LOW_NOISE:
                exp_row = aisf_pkg::CORNER_EXP_LOW_NOISE;
            aisf_pkg::OSM_HIGH_RES:
                exp_row = aisf_pkg::CORNER_EXP_HIGH_RES;
            default: exp_row = aisf_pkg::CORNER_EXP_LOW_POWER;
        endcase
        base_exp = exp_row[{rate_index_i, 2'b00} +: 4];
        // Each select step halves the corner
        corner_nxt = base_exp - {2'b00, cutoff_nxt};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            fs_g_r <= 4'h2;
            fs_rsvd_r <= 1'b0;
            corner_r <= 4'h0;
        end
        else
        begin
            fs_g_r <= fs_g_nxt;
            fs_rsvd_r <= fs_rsvd_nxt;
            corner_r <= corner_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd_i && addr_hi_zero)
        begin
            if (addr_lo == aisf_pkg::OFS_INT_SOURCE)
            begin
                rdata_nxt[aisf_pkg::BIT_SRC_ORIENT] = orient_flag_r;
                rdata_nxt[aisf_pkg::BIT_SRC_TAP] = tap_flag_r;
                rdata_nxt[aisf_pkg::BIT_SRC_FALL] = fall_flag_r;
                rdata_nxt[aisf_pkg::BIT_SRC_READY] = ready_flag_r;
            end
            else if (addr_lo == aisf_pkg::OFS_DEVICE_IDENTITY)
                rdata_nxt = aisf_pkg::IDENTITY_CODE;
            else if (addr_lo == aisf_pkg::OFS_OUTPUT_RANGE_CONFIG)
            begin
                rdata_nxt[aisf_pkg::BIT_HP_OUT] = hp_out_r;
                rdata_nxt[1:0] = range_r;
            end
            else if (addr_lo == aisf_pkg::OFS_HIGHPASS_CUTOFF_CONFIG)
            begin
                rdata_nxt[aisf_pkg::BIT_TAP_HP_BYP] = tap_hp_byp_r;
                rdata_nxt[aisf_pkg::BIT_TAP_LP_EN] = tap_lp_en_r;
                rdata_nxt[1:0] = cutoff_r;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            rvalid_r <= reg_rd_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb
    begin
        reg_rdata_o = rdata_r;
        reg_rvalid_o = rvalid_r;
        tap_irq_flag_o = tap_flag_r;
        fall_motion_irq_flag_o = fall_flag_r;
        sample_ready_irq_flag_o = ready_flag_r;
        orientation_irq_flag_o = orient_flag_r;
        highpass_output_select_o = hp_out_r;
        range_select_o = range_r;
        full_scale_g_o = fs_g_r;
        range_reserved_o = fs_rsvd_r;
        tap_highpass_bypass_o = tap_hp_byp_r;
        tap_lowpass_enable_o = tap_lp_en_r;
        highpass_corner_exp_o = corner_r;
    end

endmodule
